// File: verilog/dhrp_top.sv
// parallel host read port: control register 2, group check writes,
// flag/index/packet reads with ready handshake and dma
// assumes packet bytes and status come from the decoder on clock_in
`timescale 1ns/1ps
`include "dhrp_consts.svh"

// Summary of operation
// - control_two bit6 holds block sync cleared
// - control_two bit5 sets dma acknowledge polarity
// - control_two bit4 sets dma request polarity
// - control_two bit3 picks early or late ready
// - control_two bit2 passes uncorrected frames at slot
// - control_two bit1 picks read or acknowledge strobe
// - control_two bit0 enables dma for packet reads
// - chip select, read, ready low before data, or with data when late
// - lane width follows bus width select
// - address 6 bytes feed group check
// - group check result in flags and pin
// - read map: data 0, flags 1, index 2
// - receive flags bit layout as documented
// - bit4 set for failed or uncorrectable packets
// - realtime flag only in its frame variant
// - block index gives output block number
// - flags and index change as event falls
// - each packet gives exactly 22 bytes
// - 22 reads narrow, 11 reads wide
// - earliest bit lowest, low byte first
module dhrp_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [3:0] addr_in,
	input wire logic cs_b_in,
	input wire logic rd_b_in,
	input wire logic wr_b_in,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic [1:0] data_oe_out,
	output logic ready_out,
	input wire logic bus_width_select_in,
	input wire logic interface_select_in,
	input wire logic dma_acknowledge_in,
	output logic dma_request_out,
	output logic event_signal_out,
	output logic group_check_ok_out,
	output logic block_sync_clear_out,
	input wire logic group_check_restart_in,
	input wire logic pkt_announce_in,
	input wire logic pkt_vertical_slot_in,
	input wire logic [7:0] pkt_flags_in,
	input wire logic [7:0] pkt_block_in,
	input wire logic realtime_variant_in,
	input wire logic [7:0] pkt_byte_in,
	input wire logic pkt_valid_in,
	output logic pkt_ready_out
);
	// ************************************************************
	// timing and pin capture
	// ************************************************************
	localparam int RDY_CYC = (`DHRP_RDY_REG_NS + `DHRP_CLK_NS - 1) / `DHRP_CLK_NS;
	localparam int WIDE_CYC = (`DHRP_RDY_WIDE_NS + `DHRP_CLK_NS - 1) / `DHRP_CLK_NS;
	localparam int EVT_CYC = (`DHRP_EVT_LOW_NS + `DHRP_CLK_NS - 1) / `DHRP_CLK_NS;
	localparam logic [25:0] PIN_RESET = {4'h0, 3'h7, 16'h0000, 3'h0};

	logic [25:0] pin_meta_reg;
	logic [25:0] pin_sync_reg;
	logic [3:0] addr_s;
	logic cs_s;
	logic rd_s;
	logic wr_s;
	logic [15:0] data_s;
	logic wide_s;
	logic parallel;
	logic dma_acknowledge_s;

	// two stages on every pin; strobes idle high during reset
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_reg <= PIN_RESET;
			pin_sync_reg <= PIN_RESET;
		end else begin
			pin_meta_reg <= {addr_in, cs_b_in, rd_b_in, wr_b_in, data_in,
				bus_width_select_in, interface_select_in, dma_acknowledge_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign addr_s = pin_sync_reg[25:22];
	assign cs_s = pin_sync_reg[21];
	assign rd_s = pin_sync_reg[20];
	assign wr_s = pin_sync_reg[19];
	assign data_s = pin_sync_reg[18:3];
	assign wide_s = pin_sync_reg[2];
	assign parallel = ~pin_sync_reg[1];
	assign dma_acknowledge_s = pin_sync_reg[0];

	// ************************************************************
	// write side: control register 2 and group check bytes
	// ************************************************************
	logic [6:0] control_two_reg;
	logic wr_prev_reg;
	logic wr_done;
	logic wr_control_two;
	logic wr_check;
	logic dma_acknowledge_pol;
	logic dma_request_pol;
	logic rdy_late;
	logic dma_on;
	logic dma_path;

	// writes land on the trailing edge of the write strobe; data hold
	// shorter than a clock relies on the host keeping the bus a cycle
	assign wr_done = wr_s & ~wr_prev_reg & ~cs_s;
	assign wr_control_two = wr_done & (addr_s == `DHRP_ADDR_CONTROL_TWO);
	assign wr_check = wr_done & (addr_s == `DHRP_ADDR_CHECK);

	// bit 7 is not stored, so it can never steer anything
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_prev_reg <= 1'b1;
			control_two_reg <= `DHRP_CONTROL_TWO_RESET;
		end else begin
			wr_prev_reg <= wr_s;
			if (wr_control_two)
				control_two_reg <= data_s[6:0];
		end
	end

	// dma settings only count on the parallel interface
	assign block_sync_clear_out = control_two_reg[`DHRP_C2_SYNC_CLR];
	assign dma_acknowledge_pol = parallel & control_two_reg[`DHRP_C2_ACK_POL];
	assign dma_request_pol = parallel & control_two_reg[`DHRP_C2_REQ_POL];
	assign rdy_late = parallel & control_two_reg[`DHRP_C2_RDY_LATE];
	assign dma_on = parallel & control_two_reg[`DHRP_C2_DMA_EN];
	assign dma_path = dma_on & control_two_reg[`DHRP_C2_DMA_ACK];

	// every write to address 6 is one more byte of the group
	dhrp_group_check u_check (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.restart_in(group_check_restart_in),
		.byte_valid_in(wr_check),
		.byte_in(data_s[7:0]),
		.ok_out(group_check_ok_out)
	);

	// ************************************************************
	// packet intake, status capture and event
	// ************************************************************
	dhrp_stream_if #(.W(8)) fill_if ();
	dhrp_stream_if #(.W(8)) drain_if ();
	logic accept;
	logic discard_reg;
	logic [7:0] flags_reg;
	logic [7:0] block_reg;
	logic [3:0] evt_reg;
	logic [4:0] remain_reg;
	logic pop;

	// uncorrected frame at the vertical slot is dropped unless passed
	assign accept = pkt_announce_in & ~(pkt_vertical_slot_in
		& ~pkt_flags_in[`DHRP_F_VDONE] & ~control_two_reg[`DHRP_C2_UNVER_OUT]);
	assign fill_if.valid = pkt_valid_in & ~discard_reg;
	assign fill_if.data = pkt_byte_in;
	assign pkt_ready_out = discard_reg | fill_if.ready;

	// flush on a new packet so a short read never shifts the next
	dhrp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.flush_in(accept),
		.fill(fill_if),
		.drain(drain_if)
	);

	// status and index swap in the same edge the event goes low
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			discard_reg <= 1'b0;
			flags_reg <= `DHRP_FLAGS_RESET;
			block_reg <= `DHRP_BLOCK_RESET;
			evt_reg <= 4'h0;
		end else if (pkt_announce_in) begin
			discard_reg <= ~accept;
			if (accept) begin
				flags_reg <= {pkt_flags_in[7:1],
					pkt_flags_in[`DHRP_F_REALTIME_INFO_BLOCK] & realtime_variant_in};
				block_reg <= pkt_block_in;
				evt_reg <= 4'(EVT_CYC);
			end
		end else if (evt_reg != 4'h0) begin
			evt_reg <= evt_reg - 4'h1;
		end
	end

	assign event_signal_out = (evt_reg == 4'h0);

	// byte budget of the current packet; a new packet wins over a pop
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			remain_reg <= 5'h00;
		else if (accept)
			remain_reg <= `DHRP_PKT_BYTES;
		else if (pop)
			remain_reg <= remain_reg - 5'h01;
	end

	// ************************************************************
	// read handshake
	// ************************************************************
	dhrp_pkg::dhrp_rd_state_t st_reg;
	logic strobe_act;
	logic [3:0] eff_addr;
	logic [3:0] addr_reg;
	logic [3:0] wait_reg;
	logic [1:0] pops_reg;
	logic lane_reg;
	logic wide_reg;
	logic [15:0] data_reg;
	logic [15:0] reg_word;
	logic [1:0] want;
	logic dma_request;

	// under dma with acknowledge strobing, the address is implied 0
	assign strobe_act = dma_path ? (dma_acknowledge_s == dma_acknowledge_pol) : (~cs_s & ~rd_s);
	assign eff_addr = dma_path ? `DHRP_ADDR_DATA : addr_s;
	assign pop = (st_reg == dhrp_pkg::RD_FETCH) & (pops_reg != 2'h0) & drain_if.valid;
	assign drain_if.ready = pop;

	// register words; reserved addresses read zero
	always_comb begin
		reg_word = 16'h0000;
		case (eff_addr)
			`DHRP_ADDR_FLAGS: reg_word = {8'h00, flags_reg[7:2],
				group_check_ok_out, flags_reg[0]};
			`DHRP_ADDR_BLOCK: reg_word = {8'h00, block_reg};
			default: reg_word = 16'h0000;
		endcase
	end

	// bytes left may be fewer than the width asks for
	always_comb begin
		want = wide_s ? 2'h2 : 2'h1;
		if (remain_reg < 5'(want))
			want = remain_reg[1:0];
	end

	// fetch holds ready for the access time, stretched while the
	// buffer runs dry; drive holds data until the strobe lifts
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= dhrp_pkg::RD_IDLE;
			addr_reg <= 4'h0;
			wait_reg <= 4'h0;
			pops_reg <= 2'h0;
			lane_reg <= 1'b0;
			wide_reg <= 1'b0;
			data_reg <= 16'h0000;
		end else begin
			case (st_reg)
				dhrp_pkg::RD_IDLE: begin
					if (strobe_act) begin
						st_reg <= dhrp_pkg::RD_FETCH;
						addr_reg <= eff_addr;
						wide_reg <= wide_s;
						lane_reg <= 1'b0;
						data_reg <= reg_word;
						if (eff_addr == `DHRP_ADDR_DATA) begin
							wait_reg <= wide_s ? 4'(WIDE_CYC) : 4'(RDY_CYC);
							pops_reg <= want;
						end else begin
							wait_reg <= 4'(RDY_CYC);
							pops_reg <= 2'h0;
						end
					end
				end
				dhrp_pkg::RD_FETCH: begin
					if (wait_reg > 4'h1)
						wait_reg <= wait_reg - 4'h1;
					if (pop) begin
						data_reg[{lane_reg, 3'h0} +: 8] <= drain_if.data;
						lane_reg <= 1'b1;
						pops_reg <= pops_reg - 2'h1;
					end
					if (wait_reg <= 4'h1 && pops_reg == 2'h0)
						st_reg <= dhrp_pkg::RD_DRIVE;
				end
				dhrp_pkg::RD_DRIVE: begin
					if (!strobe_act)
						st_reg <= dhrp_pkg::RD_IDLE;
				end
				default: st_reg <= dhrp_pkg::RD_IDLE;
			endcase
		end
	end

	// early mode drops ready while fetching, late mode while driving
	assign ready_out = rdy_late ? (st_reg != dhrp_pkg::RD_DRIVE)
		: (st_reg != dhrp_pkg::RD_FETCH);
	assign data_out = data_reg;
	assign data_oe_out = (st_reg == dhrp_pkg::RD_DRIVE) ? {wide_reg, 1'b1} : 2'h0;

	// request while packet bytes wait and the port is free
	assign dma_request = dma_on & (st_reg == dhrp_pkg::RD_IDLE)
		& (remain_reg != 5'h00) & drain_if.valid;
	assign dma_request_out = dma_request_pol ? dma_request : ~dma_request;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence early_start_s;
		st_reg == dhrp_pkg::RD_IDLE && strobe_act && !rdy_late;
	endsequence
	sequence late_drive_s;
		$rose(st_reg == dhrp_pkg::RD_DRIVE) && rdy_late;
	endsequence

	sync_clear_a: assert property (wr_control_two |=>
		block_sync_clear_out == $past(data_s[6]))
		else $error("block sync clear does not follow write");
	ack_pol_a: assert property (dma_path && st_reg == dhrp_pkg::RD_IDLE
		&& dma_acknowledge_s == dma_acknowledge_pol |=> st_reg == dhrp_pkg::RD_FETCH)
		else $error("acknowledge polarity not honoured");
	// with dma off the request sits at its inactive level, which follows polarity
	req_idle_a: assert property (!dma_on |->
		dma_request_out == !(parallel && control_two_reg[`DHRP_C2_REQ_POL]))
		else $error("dma request active with dma off");
	early_rdy_a: assert property (early_start_s |=> !ready_out [*1]
		##0 data_oe_out == 2'h0)
		else $error("early ready does not fall before data");
	late_rdy_a: assert property (late_drive_s |-> !ready_out
		&& data_oe_out[0])
		else $error("late ready not low with data driven");
	drop_a: assert property (pkt_announce_in && !accept |=>
		event_signal_out && $stable(block_reg))
		else $error("uncorrected frame was presented");
	lane_a: assert property (data_oe_out[1] |-> wide_reg)
		else $error("upper lane driven in narrow mode");
	event_a: assert property (accept |=> !event_signal_out
		&& block_reg == $past(pkt_block_in))
		else $error("index not updated with event fall");
	restart_a: assert property (accept |=> remain_reg == `DHRP_PKT_BYTES)
		else $error("read position not restarted");
	budget_a: assert property (remain_reg <= `DHRP_PKT_BYTES)
		else $error("packet byte budget exceeded");
	reserved_a: assert property ($rose(st_reg == dhrp_pkg::RD_DRIVE)
		&& addr_reg > `DHRP_ADDR_BLOCK |-> data_reg == 16'h0000)
		else $error("reserved address reads nonzero");
endmodule : dhrp_top

// File: include/dhrp_consts.svh
// register offsets, flag positions, reset values and timing figures
// assumes a single 10 MHz clock; included by bare name
`ifndef DHRP_CONSTS_SVH
`define DHRP_CONSTS_SVH
`define DHRP_ADDR_DATA 4'h0
`define DHRP_ADDR_FLAGS 4'h1
`define DHRP_ADDR_BLOCK 4'h2
`define DHRP_ADDR_CONTROL_TWO 4'h5
`define DHRP_ADDR_CHECK 4'h6
`define DHRP_CONTROL_TWO_RESET 7'h00
`define DHRP_FLAGS_RESET 8'h00
`define DHRP_BLOCK_RESET 8'h00
`define DHRP_C2_SYNC_CLR 6
`define DHRP_C2_ACK_POL 5
`define DHRP_C2_REQ_POL 4
`define DHRP_C2_RDY_LATE 3
`define DHRP_C2_UNVER_OUT 2
`define DHRP_C2_DMA_ACK 1
`define DHRP_C2_DMA_EN 0
`define DHRP_F_VDONE 7
`define DHRP_F_CHECK 1
`define DHRP_F_REALTIME_INFO_BLOCK 0
`define DHRP_PKT_BYTES 5'h16
`define DHRP_CLK_NS 100
`define DHRP_RDY_REG_NS 60
`define DHRP_RDY_WIDE_NS 300
`define DHRP_EVT_LOW_NS 1000
`define DHRP_CRC_POLY 16'h1021
`define DHRP_CRC_INIT 16'h0000
`endif

// File: include/dhrp_pkg.sv
// types shared by the host read port
// assumes nothing of its surroundings
package dhrp_pkg;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_FETCH = 2'b01,
		RD_DRIVE = 2'b10
	} dhrp_rd_state_t;
endpackage : dhrp_pkg

// File: include/dhrp_stream_if.sv
// valid/ready byte stream between the port and its buffer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface dhrp_stream_if #(parameter int W = 8) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport sender(output valid, output data, input ready);
	modport receiver(input valid, input data, output ready);
endinterface : dhrp_stream_if

// File: verilog/dhrp_fifo.sv
// packet byte buffer with flush
// assumes DEPTH a power of two, one clock
`timescale 1ns/1ps
module dhrp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic flush_in,
	dhrp_stream_if.receiver fill,
	dhrp_stream_if.sender drain
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	// honest full and empty straight from the count
	assign fill.ready = cnt_reg != (AW+1)'(DEPTH);
	assign drain.valid = cnt_reg != '0;
	assign drain.data = mem_reg[rp_reg];
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	// storage has no reset, only the pointers matter
	always_ff @(posedge clock_in) begin
		if (push)
			mem_reg[wp_reg] <= fill.data;
	end

	// flush wins over traffic in the same cycle
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else if (flush_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_reg + AW'(push);
			rp_reg <= rp_reg + AW'(pop);
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : dhrp_fifo

// File: verilog/dhrp_group_check.sv
// group check engine, fed one byte per write, earliest bit on bit 0
// assumes restart comes from the checker reset control elsewhere
`timescale 1ns/1ps
`include "dhrp_consts.svh"
module dhrp_group_check #(
	parameter logic [15:0] POLY = `DHRP_CRC_POLY,
	parameter logic [15:0] INIT = `DHRP_CRC_INIT
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic restart_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	output logic ok_out
);
	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic fb;

	// bit serial over the byte, lowest bit first
	always_comb begin
		crc_next = crc_reg;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			fb = crc_next[15] ^ byte_in[i];
			crc_next = {crc_next[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
		end
	end

	// zero remainder after the trailing check bytes means clean
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			crc_reg <= INIT;
			ok_out <= (INIT == 16'h0000);
		end else if (restart_in) begin
			crc_reg <= INIT;
			ok_out <= (INIT == 16'h0000);
		end else if (byte_valid_in) begin
			crc_reg <= crc_next;
			ok_out <= (crc_next == 16'h0000);
		end
	end
endmodule : dhrp_group_check

// File: dv/dhrp_host_model.sv
// host processor model: register reads, writes and dma acknowledge
// assumes the port samples its pins on the rising edge of clock_in
`timescale 1ns/1ps
module dhrp_host_model (
	input wire logic clock_in,
	input wire logic ready_in,
	input wire logic [1:0] oe_in,
	input wire logic [15:0] rdata_in,
	output logic [3:0] addr_out = 4'hF,
	output logic cs_b_out = 1'b1,
	output logic rd_b_out = 1'b1,
	output logic wr_b_out = 1'b1,
	output logic [15:0] wdata_out = 16'hFFFF,
	output logic ack_out = 1'b1
);
	// ***************
	// bus cycles
	// ***************
	logic ack_pol = 1'b0; // active acknowledge level
	// change acknowledge polarity and park the pin idle
	task automatic set_pol(input logic p);
		@(posedge clock_in);
		ack_pol = p;
		ack_out <= ~p;
	endtask : set_pol
	// one read by strobe or acknowledge; held until the lanes drive
	task automatic rd(input logic [3:0] a, input logic ack, output logic [15:0] d,
		output logic [1:0] oe, output logic rdy);
		int n;
		n = 0;
		@(posedge clock_in);
		addr_out <= a;
		if (ack) begin
			ack_out <= ack_pol;
		end else begin
			cs_b_out <= 1'b0;
			rd_b_out <= 1'b0;
		end
		do begin
			@(negedge clock_in);
			n++;
		end while (oe_in === 2'b00 && n < 40);
		d = rdata_in;
		oe = oe_in;
		rdy = ready_in;
		@(posedge clock_in);
		cs_b_out <= 1'b1;
		rd_b_out <= 1'b1;
		ack_out <= ~ack_pol;
		// gap well past 150 ns, since pins pass a synchroniser
		repeat (5) @(posedge clock_in);
	endtask : rd
	// one write; address, data and select outlast the strobe rise
	task automatic wr(input logic [3:0] a, input logic [7:0] v, input int gap);
		@(posedge clock_in);
		addr_out <= a;
		wdata_out <= {8'h00, v};
		cs_b_out <= 1'b0;
		wr_b_out <= 1'b0;
		repeat (3) @(posedge clock_in);
		wr_b_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		cs_b_out <= 1'b1;
		wdata_out <= {8'hFF, ~v}; // released bus shows no stale byte
		repeat (gap) @(posedge clock_in);
	endtask : wr
endmodule : dhrp_host_model

// File: dv/decoder_host_read_port_test.sv
// bench for the host read port: map, packet reads, dma, group check
// assumes dhrp_top and dhrp_host_model are compiled first
`timescale 1ns/1ps
`include "dhrp_consts.svh"
module decoder_host_read_port_test;
	// ***************
	// pins and clock
	// ***************
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic bws = 1'b0, isel = 1'b0, gcr = 1'b0, ann = 1'b0, vslot = 1'b0;
	logic rtv = 1'b1, pval = 1'b0;
	logic [7:0] pflags = 8'h00, pidx = 8'h00, pbyte = 8'h00;
	logic [3:0] addr;
	logic cs_b, rd_b, wr_b, ack, ready, req, evt, gok, bsc, prdy, r;
	logic [15:0] wdata, rdata, d;
	logic [1:0] oe, o;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	initial begin
		forever #50 clock_in = ~clock_in;
	end
	dhrp_top #(.FIFO_DEPTH(16)) i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.addr_in(addr), .cs_b_in(cs_b), .rd_b_in(rd_b), .wr_b_in(wr_b), .data_in(wdata),
		.data_out(rdata), .data_oe_out(oe), .ready_out(ready), .bus_width_select_in(bws),
		.interface_select_in(isel), .dma_acknowledge_in(ack), .dma_request_out(req),
		.event_signal_out(evt), .group_check_ok_out(gok), .block_sync_clear_out(bsc),
		.group_check_restart_in(gcr), .pkt_announce_in(ann), .pkt_vertical_slot_in(vslot),
		.pkt_flags_in(pflags), .pkt_block_in(pidx), .realtime_variant_in(rtv),
		.pkt_byte_in(pbyte), .pkt_valid_in(pval), .pkt_ready_out(prdy));
	dhrp_host_model hm (.clock_in(clock_in), .ready_in(ready), .oe_in(oe), .rdata_in(rdata),
		.addr_out(addr), .cs_b_out(cs_b), .rd_b_out(rd_b), .wr_b_out(wr_b),
		.wdata_out(wdata), .ack_out(ack));
	// ***************
	// helpers
	// ***************
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic conclude;
		$display("fails=%0d checks=%0d", fails, checks);
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	// reserved top bit of the control byte always written as zero
	task automatic ctl(input logic [6:0] v);
		hm.wr(`DHRP_ADDR_CONTROL_TWO, {1'b0, v}, 2);
	endtask : ctl
	// read, then compare lanes, ready level and the driven bytes
	task automatic rdchk(input logic [3:0] a, input logic [15:0] want, input logic [1:0] wo,
		input logic wr_, input logic by_ack);
		hm.rd(a, by_ack, d, o, r);
		check({o, r}, {wo, wr_});
		check(d & (wo[1] ? 16'hFFFF : 16'h00FF), want);
	endtask : rdchk
	task automatic announce(input logic [7:0] fl, input logic [7:0] idx, input logic vs);
		@(posedge clock_in);
		pflags <= fl;
		pidx <= idx;
		vslot <= vs;
		ann <= 1'b1;
		@(posedge clock_in);
		ann <= 1'b0;
	endtask : announce
	// event low cycles seen after an announce
	task automatic evt_len(input logic [15:0] want);
		logic [15:0] n;
		n = 16'h0000;
		repeat (20) begin
			@(negedge clock_in);
			if (evt === 1'b0) n++;
		end
		check(n, want);
	endtask : evt_len
	// packet bytes base, base+1, ... under valid/ready
	task automatic feed(input logic [7:0] base, input int cnt);
		@(posedge clock_in);
		for (int i = 0; i < cnt; i++) begin
			pbyte <= base + 8'(i);
			pval <= 1'b1;
			@(posedge clock_in);
			while (prdy !== 1'b1) @(posedge clock_in);
		end
		pval <= 1'b0;
		pbyte <= ~pbyte;
	endtask : feed
	// cut a hung run short; the sequence needs under two thousand cycles
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	// ***************
	// sequence
	// ***************
	initial begin
		repeat (10) @(posedge clock_in);
		rst_b_in <= 1'b1;
		@(negedge clock_in);
		check(rdata, 16'h0000);
		check({oe, ready, req, evt, gok, bsc, prdy}, 16'h003D);
		rdchk(`DHRP_ADDR_FLAGS, 16'h0002, 2'b01, 1'b1, 1'b0);
		rdchk(`DHRP_ADDR_BLOCK, 16'h0000, 2'b01, 1'b1, 1'b0);
		rdchk(4'h3, 16'h0000, 2'b01, 1'b1, 1'b0);
		rdchk(4'hF, 16'h0000, 2'b01, 1'b1, 1'b0);
		// first packet, narrow reads while the buffer is full
		announce(8'hF5, 8'd189, 1'b0);
		evt_len(16'd10);
		rdchk(`DHRP_ADDR_FLAGS, 16'h00F7, 2'b01, 1'b1, 1'b0);
		rdchk(`DHRP_ADDR_BLOCK, 16'h00BD, 2'b01, 1'b1, 1'b0);
		fork
			feed(8'h10, 22);
			begin
				repeat (40) @(negedge clock_in);
				check(prdy, 1'b0);
				for (int i = 0; i < 22; i++) begin
					rdchk(4'h0, {8'h00, 8'h10 + 8'(i)}, 2'b01, 1'b1, 1'b0);
				end
			end
		join
		rdchk(4'h0, 16'h0000, 2'b01, 1'b1, 1'b0);
		// late ready, wide lanes, partial packet then a fresh one
		ctl(7'h08);
		bws <= 1'b1;
		announce(8'h40, 8'd5, 1'b0);
		feed(8'h40, 5);
		rdchk(4'h0, 16'h4140, 2'b11, 1'b0, 1'b0);
		rtv <= 1'b0;
		announce(8'h21, 8'd7, 1'b0);
		fork
			feed(8'h80, 22);
			for (int i = 0; i < 11; i++) begin
				rdchk(4'h0, {8'h81 + 8'(2 * i), 8'h80 + 8'(2 * i)}, 2'b11, 1'b0, 1'b0);
			end
		join
		bws <= 1'b0;
		rdchk(`DHRP_ADDR_FLAGS, 16'h0022, 2'b01, 1'b0, 1'b0);
		// uncorrected frame at the vertical slot, refused then passed
		ctl(7'h00);
		announce(8'h00, 8'd9, 1'b1);
		evt_len(16'd0);
		feed(8'h55, 3);
		rdchk(`DHRP_ADDR_BLOCK, 16'h0007, 2'b01, 1'b1, 1'b0);
		ctl(7'h04);
		announce(8'h00, 8'd9, 1'b1);
		evt_len(16'd10);
		rdchk(`DHRP_ADDR_BLOCK, 16'h0009, 2'b01, 1'b1, 1'b0);
		// dma reads by acknowledge, both polarities
		ctl(7'h13);
		announce(8'h00, 8'd1, 1'b0);
		@(negedge clock_in);
		check(req, 1'b0);
		fork
			feed(8'hC0, 22);
			begin
				repeat (30) @(negedge clock_in);
				check(req, 1'b1);
				rdchk(4'h0, 16'h00C0, 2'b01, 1'b1, 1'b1);
				rdchk(4'h0, 16'h00C1, 2'b01, 1'b1, 1'b1);
				ctl(7'h11);
				hm.set_pol(1'b1);
				ctl(7'h33);
				rdchk(4'h0, 16'h00C2, 2'b01, 1'b1, 1'b1);
				ctl(7'h10);
				@(negedge clock_in);
				check(req, 1'b0);
				@(posedge clock_in);
				isel <= 1'b1;
				repeat (3) @(negedge clock_in);
				check(req, 1'b1);
				@(posedge clock_in);
				isel <= 1'b0;
				for (int i = 3; i < 22; i++) begin
					rdchk(4'h0, {8'h00, 8'hC0 + 8'(i)}, 2'b01, 1'b1, 1'b0);
				end
			end
		join
		// group check: a stray byte fails, zeros after restart pass
		hm.wr(`DHRP_ADDR_CHECK, 8'hA5, 12);
		check(gok, 1'b0);
		rdchk(`DHRP_ADDR_FLAGS, 16'h0000, 2'b01, 1'b1, 1'b0);
		@(posedge clock_in);
		gcr <= 1'b1;
		@(posedge clock_in);
		gcr <= 1'b0;
		repeat (3) hm.wr(`DHRP_ADDR_CHECK, 8'h00, 12);
		check(gok, 1'b1);
		rdchk(`DHRP_ADDR_FLAGS, 16'h0002, 2'b01, 1'b1, 1'b0);
		// minimal group: start marker 01, then its two check bytes, bit 0 first
		@(posedge clock_in);
		gcr <= 1'b1;
		@(posedge clock_in);
		gcr <= 1'b0;
		hm.wr(`DHRP_ADDR_CHECK, 8'h01, 12);
		check(gok, 1'b0);
		hm.wr(`DHRP_ADDR_CHECK, 8'h89, 12);
		hm.wr(`DHRP_ADDR_CHECK, 8'h11, 12);
		check(gok, 1'b1);
		// block sync clear holds until written back to zero
		ctl(7'h40);
		check(bsc, 1'b1);
		ctl(7'h00);
		check(bsc, 1'b0);
		conclude();
	end
endmodule : decoder_host_read_port_test
